// ===== common/tar_pkg.sv
// package: offsets, field layout and widths of the thermal result registers
package tar_pkg;
    localparam int ADDR_W = 8;
    localparam int RES_W = 15;
    // register indices; on the bus each register sits at four times its index
    localparam logic [7:0] OFF_BUS_HIGH = 8'h22;
    localparam logic [7:0] OFF_BUS_LOW = 8'h23;
    localparam logic [7:0] OFF_BAT_HIGH = 8'h24;
    localparam logic [7:0] OFF_BAT_LOW = 8'h25;
    localparam logic [7:0] OFF_DIE_HIGH = 8'h26;
    localparam logic [7:0] OFF_DIE_LOW = 8'h27;
    // register-aligned word: the low two address bits select nothing
    localparam int WORD_LSB = 2;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [14:0] RESULT_ZERO = 15'h0000;
    localparam int SIGN_BIT = 7;
    localparam int RES_HIGH_LSB = 8;
    localparam int RES_LOW_MSB = 7;
    // channel numbering
    localparam int CH_BUS = 0;
    localparam int CH_BAT = 1;
    localparam int CH_DIE = 2;
    localparam int N_CH = 3;
endpackage

// ===== src/tar_result_regs.sv
// thermal converter result register bank with apb slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - 0x23 holds bus thermistor low byte
// - 0x24 holds battery sign and bits 14:8
// - sign 1 means negative, two's complement
// - 0x25 holds battery thermistor low byte
// - battery result is percent of output rail
// - 0x26 holds die sign and bits 14:8
// - die temperature is 5C plus half degrees
// - 0x27 holds die temperature low byte
// - register-reset command clears; watchdog does not
// - bus high byte at 0x22, percent scale
module tar_result_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reg_reset_cmd,
    input wire logic watchdog_expired,
    input wire logic bus_thermistor_valid,
    input wire logic bus_thermistor_sign,
    input wire logic [14:0] bus_thermistor_result,
    input wire logic battery_thermistor_valid,
    input wire logic battery_thermistor_sign,
    input wire logic [14:0] battery_thermistor_result,
    input wire logic die_temperature_valid,
    input wire logic die_temperature_sign,
    input wire logic [14:0] die_temperature_result
);

    // ---------------------------------------------------------------
    // result storage
    // ---------------------------------------------------------------
    logic [tar_pkg::N_CH-1:0] valid_in;
    logic [tar_pkg::N_CH-1:0] sign_in;
    logic [14:0] result_in [tar_pkg::N_CH];
    logic [tar_pkg::N_CH-1:0] sign_reg;
    logic [14:0] result_reg [tar_pkg::N_CH];

    assign valid_in = {die_temperature_valid, battery_thermistor_valid, bus_thermistor_valid};
    assign sign_in = {die_temperature_sign, battery_thermistor_sign, bus_thermistor_sign};
    assign result_in[tar_pkg::CH_BUS] = bus_thermistor_result;
    assign result_in[tar_pkg::CH_BAT] = battery_thermistor_result;
    assign result_in[tar_pkg::CH_DIE] = die_temperature_result;

    // the undefined power-up value is modelled as zero so nothing reads x;
    // watchdog_expired is deliberately not used here
    genvar g;
    generate
        for (g = 0; g < tar_pkg::N_CH; g++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sign_reg[g] <= 1'b0;
                    result_reg[g] <= tar_pkg::RESULT_ZERO;
                end else if (reg_reset_cmd) begin
                    sign_reg[g] <= 1'b0;
                    result_reg[g] <= tar_pkg::RESULT_ZERO;
                end else if (valid_in[g]) begin
                    sign_reg[g] <= sign_in[g];
                    result_reg[g] <= result_in[g];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    function automatic logic [7:0] high_byte(input logic s, input logic [14:0] r);
        high_byte = {s, r[tar_pkg::RES_W-1:tar_pkg::RES_HIGH_LSB]};
    endfunction

    // one register per aligned word, so a byte-lane or out-of-range address
    // decodes to no register instead of aliasing onto a neighbour
    function automatic logic index_hit(input logic [31:0] addr, input logic [7:0] index);
        logic upper_clear;
        logic lane_clear;
        upper_clear = addr[31:tar_pkg::WORD_LSB+tar_pkg::ADDR_W] == '0;
        lane_clear = addr[tar_pkg::WORD_LSB-1:0] == '0;
        index_hit = upper_clear && lane_clear && addr[tar_pkg::WORD_LSB+:tar_pkg::ADDR_W] == index;
    endfunction

    logic [7:0] bus_high_byte;
    logic [7:0] bus_low_byte;
    logic [7:0] bat_high_byte;
    logic [7:0] bat_low_byte;
    logic [7:0] die_high_byte;
    logic [7:0] die_low_byte;
    logic hit_bus_h;
    logic hit_bus_l;
    logic hit_bat_h;
    logic hit_bat_l;
    logic hit_die_h;
    logic hit_die_l;
    logic mapped;
    logic [7:0] read_byte;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic access;
    logic setup;

    assign hit_bus_h = index_hit(paddr, tar_pkg::OFF_BUS_HIGH);
    assign hit_bus_l = index_hit(paddr, tar_pkg::OFF_BUS_LOW);
    assign hit_bat_h = index_hit(paddr, tar_pkg::OFF_BAT_HIGH);
    assign hit_bat_l = index_hit(paddr, tar_pkg::OFF_BAT_LOW);
    assign hit_die_h = index_hit(paddr, tar_pkg::OFF_DIE_HIGH);
    assign hit_die_l = index_hit(paddr, tar_pkg::OFF_DIE_LOW);
    assign mapped = hit_bus_h | hit_bus_l | hit_bat_h | hit_bat_l | hit_die_h | hit_die_l;

    // the two bytes of a result are not snapshotted together: a capture between
    // the high and the low read tears the value, so software rereads the high byte
    assign bus_high_byte =
        high_byte(sign_reg[tar_pkg::CH_BUS], result_reg[tar_pkg::CH_BUS]);
    assign bus_low_byte = result_reg[tar_pkg::CH_BUS][tar_pkg::RES_LOW_MSB:0];
    assign bat_high_byte =
        high_byte(sign_reg[tar_pkg::CH_BAT], result_reg[tar_pkg::CH_BAT]);
    assign bat_low_byte = result_reg[tar_pkg::CH_BAT][tar_pkg::RES_LOW_MSB:0];
    assign die_high_byte =
        high_byte(sign_reg[tar_pkg::CH_DIE], result_reg[tar_pkg::CH_DIE]);
    assign die_low_byte = result_reg[tar_pkg::CH_DIE][tar_pkg::RES_LOW_MSB:0];

    // the hits are mutually exclusive, so the chain order carries no priority
    assign read_byte =
        hit_bus_h ? bus_high_byte :
        hit_bus_l ? bus_low_byte :
        hit_bat_h ? bat_high_byte :
        hit_bat_l ? bat_low_byte :
        hit_die_h ? die_high_byte :
        hit_die_l ? die_low_byte :
        tar_pkg::BYTE_ZERO;

    assign setup = psel && !penable;
    // reads return stored codes unscaled; the percent and degree scaling
    // is applied by software
    assign prdata_next = (setup && !pwrite) ? {24'h00_0000, read_byte} : prdata;
    // writes to result offsets do nothing but are not errors; unmapped is an error
    assign pslverr_next = setup ? !mapped : pslverr;
    assign access = psel && penable;

    // no wait states: data registered at the setup edge, answered in the first access cycle
    assign pready = access;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= tar_pkg::RDATA_ZERO;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    bus_low_read_a: assert property (
        setup && !pwrite && hit_bus_l && !valid_in[0] && !reg_reset_cmd
        |=> prdata[7:0] == result_reg[0][7:0])
        else $error("bus low byte read mismatch");

    bus_capture_a: assert property (
        valid_in[0] && !reg_reset_cmd
        |=> result_reg[0] == $past(result_in[0]))
        else $error("bus result not captured");

    ready_timing_a: assert property (
        setup
        |=> pready)
        else $error("no answer after setup");

    rdata_upper_a: assert property (
        psel && penable
        |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above the low byte not zero");

    mapped_no_error_a: assert property (
        setup && mapped
        |=> !pslverr)
        else $error("error flagged on a mapped offset");

    bat_high_read_a: assert property (
        setup && !pwrite && hit_bat_h
        |=> prdata[7:0] == {$past(sign_reg[1]), $past(result_reg[1][14:8])})
        else $error("battery high byte read mismatch");

    sign_capture_a: assert property (
        valid_in[2] && !reg_reset_cmd
        |=> sign_reg[2] == $past(sign_in[2]))
        else $error("die sign not captured");

    bus_sign_capture_a: assert property (
        valid_in[0] && !reg_reset_cmd
        |=> sign_reg[0] == $past(sign_in[0]))
        else $error("bus sign not captured");

    bat_sign_capture_a: assert property (
        valid_in[1] && !reg_reset_cmd
        |=> sign_reg[1] == $past(sign_in[1]))
        else $error("battery sign not captured");

    bat_sign_read_a: assert property (
        setup && !pwrite && hit_bat_h
        |=> prdata[tar_pkg::SIGN_BIT] == $past(sign_reg[1]))
        else $error("battery sign bit read mismatch");

    die_sign_read_a: assert property (
        setup && !pwrite && hit_die_h
        |=> prdata[tar_pkg::SIGN_BIT] == $past(sign_reg[2]))
        else $error("die sign bit read mismatch");

    bat_low_read_a: assert property (
        setup && !pwrite && hit_bat_l
        |=> prdata[7:0] == $past(result_reg[1][7:0]))
        else $error("battery low byte read mismatch");

    bat_capture_a: assert property (
        valid_in[1] && !reg_reset_cmd
        |=> result_reg[1] == $past(result_in[1]))
        else $error("battery result not captured");

    die_high_read_a: assert property (
        setup && !pwrite && hit_die_h
        |=> prdata == {24'h00_0000, $past(sign_reg[2]), $past(result_reg[2][14:8])})
        else $error("die high byte read mismatch");

    die_low_read_a: assert property (
        setup && !pwrite && hit_die_l
        |=> prdata[7:0] == $past(result_reg[2][7:0]))
        else $error("die low byte read mismatch");

    die_capture_a: assert property (
        valid_in[2] && !reg_reset_cmd
        |=> result_reg[2] == $past(result_in[2]))
        else $error("die result not captured");

    reg_reset_clear_a: assert property (
        reg_reset_cmd
        |=> result_reg[0] == 15'h0000 && result_reg[1] == 15'h0000 && result_reg[2] == 15'h0000)
        else $error("register reset did not clear results");

    sign_clear_a: assert property (
        reg_reset_cmd
        |=> sign_reg == 3'h0)
        else $error("register reset did not clear signs");

    watchdog_keep_a: assert property (
        watchdog_expired && !reg_reset_cmd && valid_in == 3'h0
        |=> $stable(result_reg[1]))
        else $error("watchdog changed a result");

    watchdog_sign_a: assert property (
        watchdog_expired && !reg_reset_cmd && valid_in == 3'h0
        |=> $stable(sign_reg) && $stable(result_reg[0]) && $stable(result_reg[2]))
        else $error("watchdog changed a sign or result");

    bus_high_read_a: assert property (
        setup && !pwrite && hit_bus_h
        |=> prdata[7:0] == {$past(sign_reg[0]), $past(result_reg[0][14:8])})
        else $error("bus high byte read mismatch");

    write_ignored_a: assert property (
        setup && pwrite && !reg_reset_cmd && valid_in == 3'h0
        |=> $stable(result_reg[0]) && $stable(result_reg[2]) && (!pslverr == $past(mapped)))
        else $error("write affected a result");

    bat_write_ignored_a: assert property (
        setup && pwrite && !reg_reset_cmd && !valid_in[1]
        |=> $stable(result_reg[1]) && $stable(sign_reg[1]))
        else $error("write affected the battery result");

    write_rdata_keep_a: assert property (
        setup && pwrite
        |=> $stable(prdata))
        else $error("write changed the read data");

    unmapped_read_a: assert property (
        setup && !pwrite && !mapped
        |=> prdata == tar_pkg::RDATA_ZERO && pslverr)
        else $error("unmapped read not answered with zero and error");

    rdata_stands_a: assert property (
        !setup
        |=> $stable(prdata) && $stable(pslverr))
        else $error("read data or error moved outside a setup");

    // main scenarios: die read, bus write, unmapped error, clear over capture, fresh read
    read_die_c: cover property (setup && !pwrite && hit_die_h ##1 pready);
    write_bus_c: cover property (setup && pwrite && hit_bus_l ##1 pready);
    unmapped_c: cover property (setup && !mapped ##1 pready && pslverr);
    reset_cmd_c: cover property (reg_reset_cmd && valid_in[1]);
    capture_read_c: cover property (valid_in[0] ##2 setup && !pwrite && hit_bus_h);

endmodule

`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the thermal result register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reg_reset_cmd, watchdog_expired;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] vld, sgn;
    logic [14:0] res [3];
    logic [15:0] model [3];
    logic [31:0] rd;
    logic se;
    int err_count = 0;
    int n_compared = 0;
    tar_result_regs tar_result_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_reset_cmd(reg_reset_cmd),
        .watchdog_expired(watchdog_expired), .bus_thermistor_valid(vld[0]),
        .bus_thermistor_sign(sgn[0]), .bus_thermistor_result(res[0]),
        .battery_thermistor_valid(vld[1]), .battery_thermistor_sign(sgn[1]),
        .battery_thermistor_result(res[1]), .die_temperature_valid(vld[2]),
        .die_temperature_sign(sgn[2]), .die_temperature_result(res[2]));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer to register index a (byte address four times a), held until pready
    task automatic apb(input logic [7:0] a, input logic w);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {22'h00_0000, a, 2'h0};
        pwrite <= w;
        pstrb <= w ? 4'hf : 4'h0;
        pwdata <= $urandom;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            err_count++;
            report_and_stop();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // all three channels capture at once; clr asserts the clear in the same cycle
    task automatic cap(input logic clr);
        logic [15:0] v;
        @(posedge pclk);
        for (int c = 0; c < 3; c++) begin
            v = 16'($urandom);
            sgn[c] <= v[15];
            res[c] <= v[14:0];
            model[c] = clr ? 16'h0000 : v;
        end
        vld <= 3'b111;
        reg_reset_cmd <= clr;
        @(posedge pclk);
        vld <= 3'b000;
        reg_reset_cmd <= 1'b0;
    endtask
    task automatic rd_all(input string name, input logic w);
        for (int c = 0; c < 6; c++) begin
            apb(tar_pkg::OFF_BUS_HIGH + 8'(c), w);
            chk({31'h0000_0000, se}, 32'h0000_0000);
        end
        for (int c = 0; c < 3; c++) begin
            apb(tar_pkg::OFF_BUS_HIGH + 8'(2 * c), 1'b0);
            chk(rd, {24'h00_0000, model[c][15:8]});
            apb(tar_pkg::OFF_BUS_LOW + 8'(2 * c), 1'b0);
            chk(rd, {24'h00_0000, model[c][7:0]});
        end
        $display("test %0s done", name);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, reg_reset_cmd, watchdog_expired} = 6'h00;
        {paddr, pwdata, pstrb, vld, sgn} = '0;
        for (int c = 0; c < 3; c++) {res[c], model[c]} = '0;
        void'($urandom(3116));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_all("reset", 1'b0);
        repeat (4) begin
            cap(1'b0);
            rd_all("capture", 1'b0);
        end
        // writes go to every mapped offset, then everything is read back unchanged
        rd_all("write", 1'b1);
        @(posedge pclk);
        watchdog_expired <= 1'b1;
        @(posedge pclk);
        watchdog_expired <= 1'b0;
        rd_all("watchdog", 1'b0);
        cap(1'b1);
        rd_all("clear", 1'b0);
        for (int c = 0; c < 2; c++) begin
            apb(c ? 8'h28 : 8'h21, 1'(c));
            chk(rd, tar_pkg::RDATA_ZERO);
            chk({31'h0000_0000, se}, 32'h0000_0001);
        end
        $display("test unmapped done");
        cap(1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < 3; c++) model[c] = 16'h0000;
        rd_all("midreset", 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
